// ### core/dma_channel_event_flags.sv
// channel event flag and enable register behind an AHB-Lite slave
// assumes the transfer engine drives pointers and event pulses on sys_clk
// What this block does
// R1 - the source-done flag in bit 7 sets when the source pointer equals the source size.
// R2 - the source half flag in bit 6 sets when the source pointer reaches half the source size.
// R3 - the destination-done flag in bit 5 sets when the destination pointer equals its size.
// R4 - bit 23 enables the source-done event onto the channel interrupt.
// R5 - bit 21 enables the destination-done event onto the channel interrupt.
// R6 - bit 20 enables the destination half event onto the channel interrupt.
// R7 - bit 19 enables the block-complete event onto the channel interrupt.
// R8 - bit 18 enables the cell-complete event onto the channel interrupt.
// R9 - bit 17 enables the abort event onto the channel interrupt.
// R10 - bit 16 enables the address-error event onto the channel interrupt.
// R11 - bits 31 to 24 and 15 to 8 read zero and ignore writes.
// R12 - writes at offsets 0x4, 0x8 and 0xC clear, set or invert the bits written as one.
// R13 - the channel request is high while any flag and its enable are both one.
// R14 - software clears a flag by writing zero; a set flag holds until then.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "evf_defines.svh"
module dma_channel_event_flags
	import evf_pkg::*;
#(
	parameter int PtrWidth = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [PtrWidth-1:0] srcPointer,
	input wire logic [PtrWidth-1:0] srcSize,
	input wire logic [PtrWidth-1:0] dstPointer,
	input wire logic [PtrWidth-1:0] dstSize,
	input wire logic blockDone,
	input wire logic cellDone,
	input wire logic transferAbort,
	input wire logic addrError,
	output logic channelIrq,
	output logic sysIrq
);
	initial begin
		if (PtrWidth < 2 || PtrWidth > 32) $error("PtrWidth out of range");
	end

	// decode of the low address nibble into a write operation
	function automatic write_op_t decodeOp(input logic [3:0] ofs);
		write_op_t op;
		op = OP_WRITE;
		if (ofs == `OFS_CLR) op = OP_CLEAR;
		if (ofs == `OFS_SET) op = OP_SET;
		if (ofs == `OFS_INV) op = OP_INVERT;
		return op;
	endfunction

	// apply one write operation to an eight-bit field
	function automatic event_vec_t applyOp(input write_op_t op, input event_vec_t cur,
		input event_vec_t wd);
		event_vec_t res;
		res = cur;
		unique case (op)
			OP_WRITE: res = wd;
			OP_CLEAR: res = cur & ~wd;
			OP_SET: res = cur | wd;
			OP_INVERT: res = cur ^ wd;
		endcase
		return res;
	endfunction

	logic srcDoneHit;
	logic srcHalfHit;
	logic dstDoneHit;
	logic dstHalfHit;

	// pointer comparisons against the programmed sizes
	evf_pointer_match #(
		.PtrWidth(PtrWidth)
	) u_match (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.srcPointer(srcPointer),
		.srcSize(srcSize),
		.dstPointer(dstPointer),
		.dstSize(dstSize),
		.srcDoneHit(srcDoneHit),
		.srcHalfHit(srcHalfHit),
		.dstDoneHit(dstDoneHit),
		.dstHalfHit(dstHalfHit)
	);

	// address phase capture
	logic wrPend_reg;
	logic [3:0] wrOfs_reg;
	logic [1:0] wrWin_reg;
	wire addrPhase = hsel & htrans[1] & hready;
	wire [1:0] win = haddr[5:4];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_reg <= 1'h0;
			wrOfs_reg <= 4'h0;
			wrWin_reg <= `WIN_CHAN;
		end else if (hready) begin
			wrPend_reg <= addrPhase & hwrite;
			wrOfs_reg <= haddr[3:0];
			wrWin_reg <= win;
		end
	end

	// data phase decode: window 0 is the channel register, window 1 the
	// system status, window 2 the system mask
	wire regWrite = wrPend_reg & (wrWin_reg == `WIN_CHAN);
	wire stsWrite = wrPend_reg & (wrWin_reg == `WIN_STS);
	wire mskWrite = wrPend_reg & (wrWin_reg == `WIN_MSK) & (wrOfs_reg == `OFS_MASK);
	wire write_op_t wrOp = decodeOp(wrOfs_reg); // R12
	wire event_vec_t wrFlags = hwdata[`FLAG_LSB +: `N_EVENTS];
	wire event_vec_t wrEnables = hwdata[`ENA_LSB +: `N_EVENTS];

	// hardware events in flag bit order
	event_vec_t hwEvents;
	assign hwEvents[`BIT_SRC_DONE] = srcDoneHit; // R1
	assign hwEvents[`BIT_SRC_HALF] = srcHalfHit; // R2
	assign hwEvents[`BIT_DST_DONE] = dstDoneHit; // R3
	assign hwEvents[`BIT_DST_HALF] = dstHalfHit;
	assign hwEvents[`BIT_BLOCK] = blockDone;
	assign hwEvents[`BIT_CELL] = cellDone;
	assign hwEvents[`BIT_ABORT] = transferAbort;
	assign hwEvents[`BIT_ADDR_ERR] = addrError;

	// flag and enable state
	event_vec_t flag_reg;
	event_vec_t enable_reg;
	wire event_vec_t flagSw = regWrite ? applyOp(wrOp, flag_reg, wrFlags) : flag_reg; // R14
	wire event_vec_t flag_next = flagSw | hwEvents; // R1 R2 R3
	wire event_vec_t enable_next = regWrite ? applyOp(wrOp, enable_reg, wrEnables)
		: enable_reg; // R4 R5 R6 R7 R8 R9 R10

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= `RESET_BYTE;
			enable_reg <= `RESET_BYTE;
		end else begin
			flag_reg <= flag_next;
			enable_reg <= enable_next;
		end
	end

	// channel request from enabled flags
	assign channelIrq = |(flag_reg & enable_reg); // R13 R4 R5 R6 R7 R8 R9 R10

	// system status register: sticky copy of events, one-to-clear, masked
	event_vec_t sysStatus;
	event_vec_t sysMask;
	evf_status_mask #(
		.Width(`N_EVENTS)
	) u_sys (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.events(hwEvents),
		.clearBits(stsWrite ? wrFlags : `RESET_BYTE),
		.maskWrite(mskWrite),
		.maskData(wrFlags),
		.status(sysStatus),
		.mask(sysMask),
		.irq(sysIrq)
	);

	// read data, registered at the address phase
	wire [31:0] chanWord = ({8'h00, enable_reg, 8'h00, flag_reg}) & `IMPL_MASK; // R11
	wire [31:0] rdSel = (win == `WIN_CHAN) ? chanWord
		: (win == `WIN_STS) ? {24'h000000, sysStatus}
		: (win == `WIN_MSK) ? {24'h000000, sysMask}
		: 32'h00000000;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) hrdata <= 32'h00000000;
		else if (addrPhase & ~hwrite) hrdata <= rdSel;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

// ### core/evf_defines.svh
// field positions, offsets and reset values of the channel event register
// assumes inclusion by bare name from the design files
`ifndef EVF_DEFINES_SVH
`define EVF_DEFINES_SVH
`define OFS_BASE 4'h0
`define OFS_CLR 4'h4
`define OFS_SET 4'h8
`define OFS_INV 4'hC
`define OFS_MASK 4'h0
`define FLAG_LSB 0
`define ENA_LSB 16
`define N_EVENTS 8
`define BIT_SRC_DONE 3'h7
`define BIT_SRC_HALF 3'h6
`define BIT_DST_DONE 3'h5
`define BIT_DST_HALF 3'h4
`define BIT_BLOCK 3'h3
`define BIT_CELL 3'h2
`define BIT_ABORT 3'h1
`define BIT_ADDR_ERR 3'h0
`define RESET_BYTE 8'h00
`define IMPL_MASK 32'h00FF00FF
`define WIN_CHAN 2'h0
`define WIN_STS 2'h1
`define WIN_MSK 2'h2
`endif

// ### core/evf_pkg.sv
// types shared by the event flag block
// assumes evf_defines.svh sits beside it
package evf_pkg;
	typedef enum logic [1:0] {
		OP_WRITE,
		OP_CLEAR,
		OP_SET,
		OP_INVERT
	} write_op_t;
	typedef logic [7:0] event_vec_t;
endpackage

// ### core/evf_pointer_match.sv
// pointer compare: reports the cycle each pointer condition becomes true
// assumes pointers and sizes come from logic on sys_clk
`timescale 1ns/1ps
`include "evf_defines.svh"
module evf_pointer_match #(
	parameter int PtrWidth = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [PtrWidth-1:0] srcPointer,
	input wire logic [PtrWidth-1:0] srcSize,
	input wire logic [PtrWidth-1:0] dstPointer,
	input wire logic [PtrWidth-1:0] dstSize,
	output logic srcDoneHit,
	output logic srcHalfHit,
	output logic dstDoneHit,
	output logic dstHalfHit
);
	initial begin
		if (PtrWidth < 2) $error("PtrWidth too small");
	end

	logic [3:0] levels;
	logic [3:0] prev_reg;

	// level conditions of the four pointer events
	assign levels[3] = (srcPointer == srcSize);
	assign levels[2] = (srcPointer == (srcSize >> 1));
	assign levels[1] = (dstPointer == dstSize);
	assign levels[0] = (dstPointer == (dstSize >> 1));

	// rising edge so a flag cleared while the pointer rests stays clear;
	// resets high so pointer equal to size at release is no false event
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) prev_reg <= '1;
		else prev_reg <= levels;
	end

	assign srcDoneHit = levels[3] & ~prev_reg[3];
	assign srcHalfHit = levels[2] & ~prev_reg[2];
	assign dstDoneHit = levels[1] & ~prev_reg[1];
	assign dstHalfHit = levels[0] & ~prev_reg[0];
endmodule

// ### core/evf_status_mask.sv
// sticky status bits with one-to-clear and a mask onto one level output
// assumes events are sys_clk pulses
`timescale 1ns/1ps
`include "evf_defines.svh"
module evf_status_mask #(
	parameter int Width = 2
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [Width-1:0] events,
	input wire logic [Width-1:0] clearBits,
	input wire logic maskWrite,
	input wire logic [Width-1:0] maskData,
	output logic [Width-1:0] status,
	output logic [Width-1:0] mask,
	output logic irq
);
	initial begin
		if (Width < 1) $error("Width must be positive");
	end

	logic [Width-1:0] status_reg;
	logic [Width-1:0] mask_reg;

	// set wins over clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) status_reg <= '0;
		else status_reg <= (status_reg & ~clearBits) | events;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) mask_reg <= '0;
		else if (maskWrite) mask_reg <= maskData;
	end

	assign status = status_reg;
	assign mask = mask_reg;
	assign irq = |(status_reg & mask_reg);
endmodule

// ### sim/dma_channel_event_flags_assertions.sv
// checker on the channel event register ports
// assumes binding onto the design top, one clock domain
`timescale 1ns/1ps
module evf_checker #(
	parameter int PtrWidth = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [PtrWidth-1:0] srcPointer,
	input wire logic [PtrWidth-1:0] srcSize,
	input wire logic [PtrWidth-1:0] dstPointer,
	input wire logic [PtrWidth-1:0] dstSize,
	input wire logic blockDone,
	input wire logic transferAbort,
	input wire logic channelIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// address phase of a read of the main register
	sequence s_rd0;
		hsel && htrans[1] && hready && !hwrite && haddr[5:0] == 6'h00;
	endsequence
	// an event, then a read two cycles on
	sequence s_ev(e);
		e ##2 s_rd0;
	endsequence
	property p_okay;
		hreadyout && !hresp;
	endproperty
	property p_unimp;
		s_rd0 |=> (hrdata & 32'hFF00FF00) == 32'h0;
	endproperty
	property p_irq;
		s_rd0 |=> $past(channelIrq) == |(hrdata[23:16] & hrdata[7:0]);
	endproperty
	property p_srcDone;
		s_ev($rose(srcPointer == srcSize)) |=> hrdata[7];
	endproperty
	property p_srcHalf;
		s_ev($rose(srcPointer == (srcSize >> 1))) |=> hrdata[6];
	endproperty
	property p_dstDone;
		s_ev($rose(dstPointer == dstSize)) |=> hrdata[5];
	endproperty
	property p_block;
		s_ev(blockDone) |=> hrdata[3];
	endproperty
	property p_abort;
		s_ev(transferAbort) |=> hrdata[1];
	endproperty
	a_okay: assert property (p_okay) else $error("wait state or error response");
	a_unimp: assert property (p_unimp) else $error("reserved bits read nonzero");
	a_irq: assert property (p_irq) else $error("request disagrees with register");
	a_srcDone: assert property (p_srcDone) else $error("source done flag missing");
	a_srcHalf: assert property (p_srcHalf) else $error("source half flag missing");
	a_dstDone: assert property (p_dstDone) else $error("destination done flag missing");
	a_block: assert property (p_block) else $error("block flag missing");
	a_abort: assert property (p_abort) else $error("abort flag missing");
endmodule
bind dma_channel_event_flags evf_checker #(.PtrWidth(PtrWidth)) evf_checker_i (.*);

// ### sim/dma_engine_model.sv
// model of the channel transfer engine walking its pointers
// assumes start and fault requests from the bench on sys_clk
`timescale 1ns/1ps
module dma_engine_model #(
	parameter int W = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic slow,
	input wire logic [1:0] fault,
	input wire logic [W-1:0] size,
	output logic [W-1:0] srcPointer,
	output logic [W-1:0] srcSize,
	output logic [W-1:0] dstPointer,
	output logic [W-1:0] dstSize,
	output logic blockDone,
	output logic cellDone,
	output logic transferAbort,
	output logic addrError
);
	logic run, tick;
	logic [W-1:0] ptr;
	// slow mode steps every other cycle
	wire step = run && (tick || !slow);
	assign srcPointer = ptr;
	assign dstPointer = ptr;
	assign dstSize = srcSize;
	// pointer walk; blockDone a one-cycle pulse, cellDone high on every step, faults passed on a cycle late
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{run, tick, ptr, blockDone, cellDone, transferAbort, addrError} <= '0;
			srcSize <= '1; // never matches an idle zero pointer
		end else begin
			tick <= !tick;
			cellDone <= step;
			blockDone <= step && ptr + 1'h1 == srcSize;
			{transferAbort, addrError} <= fault;
			if (start) begin
				run <= 1'h1;
				ptr <= '0;
				srcSize <= size;
			end else if (step) begin
				ptr <= ptr + 1'h1;
				run <= ptr + 1'h1 != srcSize;
			end
		end
	end
endmodule

// ### sim/tb_dma_channel_event_flags.sv
// self-checking bench for the channel event register
// assumes design files and engine model compiled first
`timescale 1ns/1ps
`include "evf_defines.svh"
module tb_dma_channel_event_flags;
	logic sys_clk = '0, rstn = '0, hsel = '0, hwrite = '0, start = '0, slow = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q, r, seed = 32'h47;
	logic [1:0] htrans = '0, fault = '0;
	logic [15:0] size = '0, srcPointer, srcSize, dstPointer, dstSize;
	logic blockDone, cellDone, transferAbort, addrError;
	logic hreadyout, hresp, channelIrq, sysIrq;
	int failCount = 0, nCompared = 0;
	dma_channel_event_flags dma_channel_event_flags_i (.*, .hsize(3'h2), .hready(hreadyout));
	dma_engine_model dma_engine_model_i (.*);
	// free-running bus clock
	initial forever #25 sys_clk = ~sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] alias_exp(input int op, input logic [31:0] b, v);
		case (op)
			0: return b & ~v & `IMPL_MASK;
			1: return (b | v) & `IMPL_MASK;
			default: return (b ^ v) & `IMPL_MASK;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, got);
		nCompared++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask
	// let a write land, then look at both request lines
	task automatic irq_is(input logic c, s);
		@(posedge sys_clk);
		chk("channelIrq", {31'h0, c}, {31'h0, channelIrq});
		chk("sysIrq", {31'h0, s}, {31'h0, sysIrq});
	endtask
	task automatic reportAndStop;
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		xfer(1'h0, 32'h0, 32'h0);
		chk("reset value", 32'h0, q);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			r = seed;
			xfer(1'h1, 32'h0, r);
			seed = lfsr(seed);
			xfer(1'h1, 4 * (i % 3 + 1), seed);
			xfer(1'h0, 32'h0, 32'h0);
			chk("alias write", alias_exp(i % 3, r, seed), q);
		end
		for (int i = 0; i < 8; i++) begin
			xfer(1'h1, 32'h0, 32'h10001 << i);
			irq_is(1'h1, 1'h0);
			xfer(1'h0, 32'h0, 32'h0);
			chk("enable readback", 32'h10001 << i, q);
			xfer(1'h1, 32'h0, (32'h10000 << i) | (~(32'h1 << i) & 32'hFF));
			irq_is(1'h0, 1'h0);
		end
		for (int k = 0; k < 2; k++) begin
			xfer(1'h1, 32'h0, 32'h0);
			seed = lfsr(seed);
			size <= {seed[3:0], 1'h0} + 16'h4;
			slow <= k[0];
			start <= 1'h1;
			@(posedge sys_clk);
			start <= 1'h0;
			do @(posedge sys_clk); while (blockDone !== 1'h1);
			@(posedge sys_clk);
			xfer(1'h0, 32'h0, 32'h0);
			chk("run flags", 32'hFC, q);
		end
		xfer(1'h1, 32'h0, 32'h0);
		for (int k = 0; k < 2; k++) begin
			fault <= 2'h2 >> k;
			repeat (3) @(posedge sys_clk);
			fault <= 2'h0;
			xfer(1'h0, 32'h0, 32'h0);
			chk("fault flags", 32'h2 | k, q);
		end
		xfer(1'h1, 32'h20, 32'hFF);
		irq_is(1'h0, 1'h1);
		xfer(1'h1, 32'h18, 32'hFF);
		irq_is(1'h0, 1'h0);
		xfer(1'h0, 32'h10, 32'h0);
		chk("system status", 32'h0, q);
		xfer(1'h1, 32'h30, seed);
		xfer(1'h0, 32'h30, 32'h0);
		chk("unmapped", 32'h0, q);
		xfer(1'h0, 32'h0, 32'h0);
		chk("held flags", 32'h3, q);
		reportAndStop();
	end
	// cut a hang short well past the expected run length
	initial begin
		#2000000;
		failCount++;
		reportAndStop();
	end
endmodule
